// [src/smwm_fifo.sv]
`timescale 1ns/1ns
module smwm_fifo
    import smwm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int DEPTH_LOG2 = 5,
    parameter bit IN_BLOCK_RAM = 1'b1
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side.
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    output logic full_o,
    // Drain side; the head word is valid whenever empty is low.
    input wire logic pop_i,
    output logic [WIDTH-1:0] head_o,
    output logic empty_o
);

    // Storage array; both styles share one array, so they differ only in whether reset clears the entries.
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [DEPTH_LOG2-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [DEPTH_LOG2:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    // Pushes while full and pops while empty are dropped.
    always_comb begin
        do_push = push_i && !full_o;
        do_pop = pop_i && !empty_o;
        wr_d = do_push ? wr_q + 1'b1 : wr_q;
        rd_d = do_pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (DEPTH_LOG2+1)'(do_push) - (DEPTH_LOG2+1)'(do_pop);
    end

    // Pointer and count registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Memory write port. The block-memory style has no reset so it can map onto
    // on-chip memory; the register style clears its entries, at one flip-flop per bit.
    if (IN_BLOCK_RAM) begin : g_block_ram
        always_ff @(posedge clk_i) begin
            if (do_push) begin
                mem_q[wr_q] <= push_data_i;
            end
        end
    end else begin : g_registers
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                mem_q <= '{default: '0};
            end else if (do_push) begin
                mem_q[wr_q] <= push_data_i;
            end
        end
    end

    // Asynchronous read keeps the head visible; block-RAM style relies on
    // the tool absorbing the read into memory with an output register.
    assign head_o = mem_q[rd_q];
    assign full_o = (cnt_q == (DEPTH_LOG2+1)'(DEPTH));
    assign empty_o = (cnt_q == '0);

endmodule

// [src/smwm_pkg.sv]
package smwm_pkg;

    // Default geometry of the write master.
    localparam int SMWM_WORD_BITS_DEF = 32;
    localparam int SMWM_ADDR_BITS_DEF = 32;
    localparam int SMWM_DEPTH_DEF = 32;
    localparam int SMWM_DEPTH_LOG2_DEF = 5;
    localparam bit SMWM_BRAM_DEF = 1'b1;

    // Legal ranges checked at elaboration.
    localparam int SMWM_WORD_BITS_MIN = 8;
    localparam int SMWM_WORD_BITS_MAX = 1024;
    localparam int SMWM_ADDR_BITS_MIN = 1;
    localparam int SMWM_ADDR_BITS_MAX = 32;
    localparam int SMWM_DEPTH_LOG2_MIN = 2;
    localparam int SMWM_DEPTH_LOG2_MAX = 7;
    localparam int SMWM_LANE_BITS = 8;

    // Sequencer states.
    typedef enum logic [1:0] {
        SMWM_IDLE = 2'b00,
        SMWM_FETCH = 2'b01,
        SMWM_WRITE = 2'b10
    } smwm_state_e;

    // Transfer command held by the sequencer.
    typedef struct packed {
        logic fixed;
        logic [31:0] addr;
        logic [31:0] remain;
    } smwm_cmd_s;

endpackage

// [src/smwm_top.sv]
`timescale 1ns/1ns
module smwm_top
    import smwm_pkg::*;
#(
    parameter int word_bits = SMWM_WORD_BITS_DEF,
    parameter int lane_count = word_bits / SMWM_LANE_BITS,
    parameter int addr_bits = SMWM_ADDR_BITS_DEF,
    parameter int buffer_depth = SMWM_DEPTH_DEF,
    parameter int buffer_depth_log2 = SMWM_DEPTH_LOG2_DEF,
    parameter bit buffer_in_block_ram = SMWM_BRAM_DEF
) (
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Control interface from user logic.
    input wire logic CTRL_FIXED_I,
    input wire logic [addr_bits-1:0] CTRL_BASE_I,
    input wire logic [addr_bits-1:0] CTRL_LENGTH_I,
    input wire logic CTRL_GO_I,
    output logic CTRL_DONE_O,
    // Data interface from user logic.
    input wire logic USER_PUSH_I,
    input wire logic [word_bits-1:0] USER_DATA_I,
    output logic USER_FULL_O,
    // Avalon-MM master port.
    output logic [addr_bits-1:0] M_ADDRESS_O,
    output logic M_WRITE_O,
    output logic [lane_count-1:0] M_BYTEENABLE_O,
    output logic [word_bits-1:0] M_WRITEDATA_O,
    input wire logic M_WAITREQUEST_I
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks on the geometry.

    localparam int WORD_BYTES = word_bits / SMWM_LANE_BITS;

    // Word width must be a power of two inside the legal range.
    if (word_bits < SMWM_WORD_BITS_MIN || word_bits > SMWM_WORD_BITS_MAX ||
        (word_bits & (word_bits - 1)) != 0) begin : g_bad_word
        $error("word_bits out of range");
    end
    // One byte lane per byte of the word.
    if (lane_count != WORD_BYTES) begin : g_bad_lanes
        $error("lane_count must equal word_bits/8");
    end
    if (addr_bits < SMWM_ADDR_BITS_MIN || addr_bits > SMWM_ADDR_BITS_MAX) begin : g_bad_addr
        $error("addr_bits out of range");
    end
    // The length port shares the address width, so it must be able to hold one word's byte count.
    if (addr_bits <= $clog2(WORD_BYTES)) begin : g_bad_length
        $error("addr_bits too narrow for one word of length");
    end
    if (buffer_depth_log2 < SMWM_DEPTH_LOG2_MIN || buffer_depth_log2 > SMWM_DEPTH_LOG2_MAX ||
        buffer_depth != (1 << buffer_depth_log2)) begin : g_bad_depth
        $error("buffer depth out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal buffer.

    logic fifo_full, fifo_empty, fifo_pop;
    logic [word_bits-1:0] fifo_head;
    logic full_q;

    // Storage style is passed straight down; register style is a poor
    // trade above four words since every entry costs flip-flops.
    smwm_fifo #(
        .WIDTH(word_bits),
        .DEPTH(buffer_depth),
        .DEPTH_LOG2(buffer_depth_log2),
        .IN_BLOCK_RAM(buffer_in_block_ram)
    ) u_fifo (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .push_i(USER_PUSH_I),
        .push_data_i(USER_DATA_I),
        .full_o(fifo_full),
        .pop_i(fifo_pop),
        .head_o(fifo_head),
        .empty_o(fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write sequencer.

    smwm_state_e state_q, state_d;
    logic [addr_bits-1:0] addr_q, addr_d;
    logic [addr_bits-1:0] remain_q, remain_d;
    logic fixed_q, fixed_d;
    logic write_q, write_d;
    logic [word_bits-1:0] data_q, data_d;
    logic done_q, done_d;
    logic go_seen_q, go_seen_d;

    localparam logic [addr_bits-1:0] STEP = addr_bits'(WORD_BYTES);

    // Next-state logic: fetch a word, present it until the slave takes it,
    // then step the address unless fixed and count down the remaining bytes.
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        remain_d = remain_q;
        fixed_d = fixed_q;
        write_d = write_q;
        data_d = data_q;
        done_d = done_q;
        go_seen_d = 1'b0;
        fifo_pop = 1'b0;
        unique case (state_q)
            SMWM_IDLE: begin
                // Latch the command; done drops so a new run is visible.
                if (CTRL_GO_I) begin
                    addr_d = CTRL_BASE_I;
                    remain_d = CTRL_LENGTH_I;
                    fixed_d = CTRL_FIXED_I;
                    done_d = 1'b0;
                    go_seen_d = 1'b1;
                    state_d = SMWM_FETCH;
                end else begin
                    done_d = 1'b1;
                end
            end
            SMWM_FETCH: begin
                // Wait for user data, then load the bus registers.
                if (remain_q == '0) begin
                    state_d = SMWM_IDLE;
                    done_d = 1'b1;
                end else if (!fifo_empty) begin
                    fifo_pop = 1'b1;
                    data_d = fifo_head;
                    write_d = 1'b1;
                    state_d = SMWM_WRITE;
                end
            end
            SMWM_WRITE: begin
                // Address, data and write stand while the slave stalls.
                if (!M_WAITREQUEST_I) begin
                    write_d = 1'b0;
                    remain_d = remain_q - STEP;
                    if (!fixed_q) begin
                        addr_d = addr_q + STEP;
                    end
                    state_d = SMWM_FETCH;
                end
            end
            default: begin
                state_d = SMWM_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= SMWM_IDLE;
            addr_q <= '0;
            remain_q <= '0;
            fixed_q <= 1'b0;
            write_q <= 1'b0;
            data_q <= '0;
            done_q <= 1'b0;
            go_seen_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            remain_q <= remain_d;
            fixed_q <= fixed_d;
            write_q <= write_d;
            data_q <= data_d;
            done_q <= done_d;
            go_seen_q <= go_seen_d;
            full_q <= fifo_full;
        end
    end

    // Full is registered so it comes from a flip-flop; it lags by a cycle,
    // so the user should also stop one word early when pushing back to back.
    assign USER_FULL_O = full_q;
    assign CTRL_DONE_O = done_q;
    assign M_ADDRESS_O = addr_q;
    assign M_WRITE_O = write_q;
    assign M_WRITEDATA_O = data_q;
    // Only whole-word writes are issued.
    assign M_BYTEENABLE_O = '1;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_lanes_all_on: assert property (M_WRITE_O |-> &M_BYTEENABLE_O)
        else $error("partial byte enables on a write");
    a_write_holds: assert property (M_WRITE_O && M_WAITREQUEST_I |=>
        M_WRITE_O && $stable(M_ADDRESS_O) && $stable(M_WRITEDATA_O))
        else $error("write changed while stalled");
    a_addr_step: assert property (M_WRITE_O && !M_WAITREQUEST_I && !fixed_q |=>
        M_ADDRESS_O == $past(M_ADDRESS_O) + STEP)
        else $error("address did not step by a word");
    a_addr_fixed: assert property (M_WRITE_O && !M_WAITREQUEST_I && fixed_q |=>
        $stable(M_ADDRESS_O))
        else $error("fixed address moved");
    a_done_late: assert property (state_q == SMWM_IDLE && CTRL_GO_I |=> !CTRL_DONE_O)
        else $error("done in start cycle");
    a_done_count: assert property (state_q == SMWM_FETCH && remain_q == '0 |=> CTRL_DONE_O)
        else $error("done missing at end");
    a_no_done_busy: assert property (M_WRITE_O |-> !CTRL_DONE_O)
        else $error("done during write");
    a_full_flag: assert property (fifo_full |=> USER_FULL_O)
        else $error("full flag not shown");

    c_stalled: cover property (M_WRITE_O && M_WAITREQUEST_I ##1 M_WRITE_O && !M_WAITREQUEST_I);
    c_full: cover property (USER_FULL_O);
    c_done: cover property (go_seen_q ##[1:100] CTRL_DONE_O);

endmodule

// [verif/smwm_slave_model.sv]
`timescale 1ns/1ns
// Memory-mapped slave that stalls each write for stall_i cycles and logs it.
module smwm_slave_model #(
    parameter int AW = 16,
    parameter int DW = 32,
    parameter int LW = 4
) (
    // Clock, reset and stall length.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] stall_i,
    // Master request.
    input wire logic [AW-1:0] addr_i,
    input wire logic write_i,
    input wire logic [LW-1:0] be_i,
    input wire logic [DW-1:0] data_i,
    output logic waitreq_o
);
    logic [7:0] wait_q; // Cycles the current write has waited.
    logic stalled_q; // The last edge saw a stalled write.
    logic [AW+DW-1:0] held_q; // Request seen at that edge.
    logic [AW-1:0] addr_q[$]; // Accepted addresses.
    logic [DW-1:0] data_q[$]; // Accepted data.
    logic [LW-1:0] be_q[$]; // Accepted byte enables.
    int hold_err = 0; // Changes seen on a stalled request.
    // Waitrequest stays high when idle, so a master never sees a free accept.
    assign waitreq_o = !(write_i && wait_q >= stall_i);
    ////////////////////////////////////////////////////////////
    // Non-blocking updates keep waitrequest stable for the design's edge.
    always @(posedge clk_i) begin
        if (stalled_q && write_i && {addr_i, data_i} !== held_q) begin
            hold_err++;
        end
        stalled_q <= write_i && waitreq_o && !rst_i;
        held_q <= {addr_i, data_i};
        if (write_i && !waitreq_o && !rst_i) begin
            addr_q.push_back(addr_i);
            data_q.push_back(data_i);
            be_q.push_back(be_i);
            wait_q <= 8'h00;
        end else begin
            wait_q <= write_i ? wait_q + 8'h01 : 8'h00;
        end
    end
endmodule

// [verif/smwm_top_tb.sv]
`timescale 1ns/1ns
module smwm_top_tb;
    import smwm_pkg::*;
    localparam int AW = 16; // Narrow address bus to exercise the width.
    logic clk, rst, fixed, go, push, full, done, wr, wq;
    logic [AW-1:0] base, len, addr;
    logic [31:0] wdata, mdata;
    logic [3:0] be;
    logic [7:0] stall;
    logic [31:0] exp_q[$]; // Words the design has accepted, in order.
    int fail_count = 0;
    int total_checks = 0;
    smwm_top #(.word_bits(32), .addr_bits(AW), .buffer_depth(4), .buffer_depth_log2(2)) dut (
        .CLK_SYS_I(clk), .RST_I(rst), .CTRL_FIXED_I(fixed), .CTRL_BASE_I(base),
        .CTRL_LENGTH_I(len), .CTRL_GO_I(go), .CTRL_DONE_O(done), .USER_PUSH_I(push),
        .USER_DATA_I(wdata), .USER_FULL_O(full), .M_ADDRESS_O(addr), .M_WRITE_O(wr),
        .M_BYTEENABLE_O(be), .M_WRITEDATA_O(mdata), .M_WAITREQUEST_I(wq));
    smwm_slave_model #(.AW(AW)) slv (
        .clk_i(clk), .rst_i(rst), .stall_i(stall), .addr_i(addr), .write_i(wr),
        .be_i(be), .data_i(mdata), .waitreq_o(wq));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Pushes one word; with room set it first waits for the full flag to drop.
    task automatic push_word(input logic [31:0] d, input bit room);
        int n;
        for (n = 0; room && full !== 1'b0; n++) begin
            if (n > 200) begin
                fail_count++;
                tally_and_finish();
            end
            @(negedge clk);
        end
        push = 1'b1;
        wdata = d;
        if (room) exp_q.push_back(d);
        @(negedge clk);
        push = 1'b0;
        // One edge passes with the strobe low, so a following push never re-drives it at once.
        @(negedge clk);
    endtask
    // Starts a transfer, waits for done and judges every logged write.
    task automatic run(input logic [AW-1:0] b, l, input logic f, input int nw, input bit again);
        int n;
        int k0;
        k0 = slv.addr_q.size();
        base = b;
        len = l;
        fixed = f;
        go = 1'b1;
        @(negedge clk);
        // A start held while busy must be ignored; the moved base shows if it was taken.
        if (again) begin
            base = 16'h7770;
        end else begin
            go = 1'b0;
        end
        chk(done, 1'b0);
        chk(slv.addr_q.size(), k0);
        if (again) begin
            @(negedge clk);
            go = 1'b0;
        end
        for (n = 0; done !== 1'b1; n++) begin
            if (n > 400) begin
                fail_count++;
                tally_and_finish();
            end
            @(negedge clk);
        end
        chk(slv.addr_q.size() - k0, nw);
        for (n = 0; n < nw; n++) begin
            chk(slv.addr_q[k0+n], f ? b : b + AW'(4 * n));
            chk(slv.data_q[k0+n], exp_q.pop_front());
            chk(slv.be_q[k0+n], 4'hF);
        end
        chk(slv.hold_err, 0);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_incr();
        stall = 8'h00;
        for (int k = 0; k < 3; k++) push_word(32'hA000_0000 + k, 1'b1);
        run(16'h0100, 16'h000C, 1'b0, 3, 1'b0);
        $display("test incr finished");
    endtask
    task automatic t_fixed();
        stall = 8'h03;
        for (int k = 0; k < 2; k++) push_word(32'hB000_0000 + k, 1'b1);
        run(16'h0240, 16'h0008, 1'b1, 2, 1'b0);
        $display("test fixed finished");
    endtask
    // Fills the buffer, offers a word it must drop, then drains it all.
    task automatic t_full();
        stall = 8'h01;
        for (int k = 0; k < 4; k++) push_word(32'hC000_0000 + k, 1'b1);
        @(negedge clk);
        chk(full, 1'b1);
        push_word(32'hDEAD_0000, 1'b0);
        chk(full, 1'b1);
        run(16'h0400, 16'h0010, 1'b0, 4, 1'b0);
        chk(full, 1'b0);
        $display("test full finished");
    endtask
    // One word, slow slave, and a second start that must be ignored.
    task automatic t_single();
        stall = 8'h05;
        push_word(32'hE000_0001, 1'b1);
        run(16'h0FFC, 16'h0004, 1'b0, 1, 1'b1);
        $display("test single finished");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        fixed = 1'b0;
        go = 1'b0;
        push = 1'b0;
        base = '0;
        len = '0;
        wdata = '0;
        stall = '0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(done, 1'b1);
        t_incr();
        t_fixed();
        t_full();
        t_single();
        tally_and_finish();
    end
endmodule
